// file: dv/spcsr_asserts.sv
// Purpose: Port-level checks of the control and status block
// Assumes: Bound into spcsr_top
// Notes:   Fault inputs pass a two-flop sync first
`timescale 1ns/1ns
`default_nettype none
module spcsr_chk #(
    parameter int OC_LIMIT = 50
) (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       logic_supply_ok,
    input wire logic       sda_oe,
    input wire logic       irq_oe,
    input wire logic       overtemp_in,
    input wire logic       overcurrent_in,
    input wire logic       input_uv_in,
    input wire logic [3:0] level_code,
    input wire logic       overcurrent_timer_en,
    input wire logic       output_active
);
    // ****************************************************************
    // Overcurrent run length
    // ****************************************************************
    logic [7:0] oc_run;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oc_run <= 8'h00;
        end else if (overcurrent_in && overcurrent_timer_en) begin
            oc_run <= (oc_run == 8'hff) ? oc_run : oc_run + 8'h01;
        end else begin
            oc_run <= 8'h00;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    ctl_reset_a: assert property (@(posedge clk_sys)
        !nrst |-> level_code == 4'h0 && !output_active && !irq_oe)
        else $error("control outputs not cleared in reset");
    bus_ignored_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) !logic_supply_ok [*5] |-> !sda_oe && !irq_oe)
        else $error("bus answered before logic supply valid");
    irq_power_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) $rose(logic_supply_ok) |-> ##[1:8] irq_oe)
        else $error("no interrupt at power-up");
    irq_ack_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) $fell(irq_oe) |-> sda_oe)
        else $error("interrupt released outside address ack");
    ot_off_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) overtemp_in [*4] |-> ##[0:3] !output_active)
        else $error("output stays on in overtemperature");
    uv_off_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) input_uv_in [*4] |-> ##[0:3] !output_active)
        else $error("output stays on in undervoltage");
    oc_cut_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        int'(oc_run) == OC_LIMIT + 4 |-> ##[0:3] !output_active)
        else $error("timed overcurrent did not cut output");
    ctl_stable_a: assert property (@(posedge clk_sys)
        disable iff (!nrst) !$stable({level_code, overcurrent_timer_en})
        |-> $past(sda_oe, 1) || $past(sda_oe, 2) || $past(sda_oe, 3))
        else $error("control changed without a write ack");
    cover property (@(posedge clk_sys) $fell(irq_oe));
    cover property (@(posedge clk_sys) $rose(output_active));
    cover property (@(posedge clk_sys) int'(oc_run) == OC_LIMIT + 4);
endmodule : spcsr_chk
bind spcsr_top spcsr_chk #(.OC_LIMIT(OC_LIMIT)) chk_u (
    .clk_sys(clk_sys), .nrst(nrst), .logic_supply_ok(logic_supply_ok),
    .sda_oe(sda_oe), .irq_oe(irq_oe), .overtemp_in(overtemp_in),
    .overcurrent_in(overcurrent_in), .input_uv_in(input_uv_in),
    .level_code(level_code), .overcurrent_timer_en(overcurrent_timer_en),
    .output_active(output_active));
`default_nettype wire

// file: dv/spcsr_master.sv
// Purpose: Two-wire bus master model driving the block
// Assumes: SDA has a pull-up; SCL is driven only here
// Notes:   Drives on falling clk_sys edges, 8 cycles per phase
`timescale 1ns/1ns
`default_nettype none
module spcsr_master (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_low
);
    // ****************************************************************
    // Bit and byte tasks
    // ****************************************************************
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half;
        repeat (8) @(negedge clk_sys);
    endtask : half
    task automatic start_c;
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start_c
    task automatic stop_c;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop_c
    task automatic bit_x(input logic b, output logic r);
        half();
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda_line;
        scl = 1'b0;
    endtask : bit_x
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~mack, r);
    endtask : rbyte
endmodule : spcsr_master
`default_nettype wire

// file: dv/supply_ctrl_status_regs_test.sv
// Purpose: Self-checking bench of the control and status block
// Assumes: Master model in spcsr_master; OC_LIMIT shortened to 5
// Notes:   Inputs change on falling clock edges
`timescale 1ns/1ns
`default_nettype none
module supply_ctrl_status_regs_test;
    import spcsr_pkg::*;
    logic       clk_sys, nrst, logic_supply_ok, scl, sda_low, sda_line;
    logic       overtemp_in, overcurrent_in, input_uv_in, below_85_in;
    logic       within_90_in, sda_out, sda_oe, irq_out, irq_oe, ack;
    logic       overcurrent_timer_en, output_active;
    logic       current_limit_sel, tone_enable;
    logic [1:0] addr_sel;
    logic [3:0] level_code;
    logic [7:0] vals [4] = '{8'h2f, 8'hd0, 8'h77, 8'ha8};
    int         n_fail, check_count;
    assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);
    spcsr_master m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));
    spcsr_top #(.OC_LIMIT(5)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .logic_supply_ok(logic_supply_ok), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_out(irq_out),
        .irq_oe(irq_oe), .addr_sel(addr_sel), .overtemp_in(overtemp_in),
        .overcurrent_in(overcurrent_in), .input_uv_in(input_uv_in),
        .below_85_in(below_85_in), .within_90_in(within_90_in),
        .level_code(level_code),
        .overcurrent_timer_en(overcurrent_timer_en),
        .output_active(output_active),
        .current_limit_sel(current_limit_sel), .tone_enable(tone_enable));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] d, input logic [1:0] a, input logic e);
        m.start_c();
        m.wbyte({ADDR_FIXED, a, 1'b0}, ack);
        check("addr ack", {7'h0, ack}, {7'h0, e});
        m.wbyte(d, ack);
        check("data ack", {7'h0, ack}, {7'h0, e});
        m.stop_c();
    endtask : wr
    task automatic rd(input logic [7:0] exp);
        logic [7:0] s;
        m.start_c();
        m.wbyte({ADDR_FIXED, addr_sel, 1'b1}, ack);
        check("read ack", {7'h0, ack}, 8'h01);
        check("irq after ack", {7'h0, irq_oe}, 8'h00);
        m.rbyte(1'b0, s);
        m.stop_c();
        check("status", s, exp);
    endtask : rd
    task automatic ctl(input logic [7:0] d, input logic act);
        check("control", {tone_enable, current_limit_sel, act,
            overcurrent_timer_en, level_code}, {d[7:6], act, d[4:0]});
        check("active", {7'h0, output_active}, {7'h0, act});
    endtask : ctl
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    // ****************************************************************
    // Clock, watchdog, tests
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
    initial begin
        {nrst, logic_supply_ok, overtemp_in, overcurrent_in} = 4'h0;
        {input_uv_in, below_85_in, within_90_in} = 3'b001;
        addr_sel = 2'h1;
        n_fail = 0;
        check_count = 0;
        wt(10);
        nrst = 1'b1;
        ctl(8'h00, 1'b0);
        wr(8'h2f, 2'h1, 1'b0);
        ctl(8'h00, 1'b0);
        logic_supply_ok = 1'b1;
        wt(10);
        check("irq power", {6'h0, irq_out, irq_oe}, 8'h01);
        rd(8'ha0);
        rd(8'h20);
        foreach (vals[i]) begin
            wr(vals[i], 2'h1, 1'b1);
            ctl(vals[i], vals[i][5]);
        end
        rd(8'h00);
        wr(8'h20, 2'h2, 1'b0);
        ctl(8'ha8, 1'b1);
        addr_sel = 2'h3;
        wr(8'h20, 2'h3, 1'b1);
        ctl(8'h20, 1'b1);
        overtemp_in = 1'b1;
        wt(10);
        check("irq ot", {7'h0, irq_oe}, 8'h01);
        ctl(8'h20, 1'b0);
        rd(8'h21);
        rd(8'h21);
        overtemp_in = 1'b0;
        wt(10);
        rd(8'h21);
        rd(8'h20);
        ctl(8'h20, 1'b0);
        wr(8'h20, 2'h3, 1'b1);
        ctl(8'h20, 1'b1);
        overcurrent_in = 1'b1;
        wt(40);
        ctl(8'h20, 1'b1);
        check("irq oc off", {7'h0, irq_oe}, 8'h00);
        rd(8'h00);
        overcurrent_in = 1'b0;
        wr(8'h30, 2'h3, 1'b1);
        overcurrent_in = 1'b1;
        wt(40);
        ctl(8'h30, 1'b0);
        check("irq oc", {7'h0, irq_oe}, 8'h01);
        wr(8'h20, 2'h3, 1'b1);
        rd(8'h02);
        rd(8'h00);
        overcurrent_in = 1'b0;
        wr(8'h20, 2'h3, 1'b1);
        {below_85_in, within_90_in} = 2'b10;
        wt(10);
        check("irq png", {7'h0, irq_oe}, 8'h00);
        rd(8'h10);
        {below_85_in, within_90_in} = 2'b01;
        wt(10);
        rd(8'h00);
        input_uv_in = 1'b1;
        wt(10);
        ctl(8'h20, 1'b0);
        rd(8'ha0);
        input_uv_in = 1'b0;
        wt(10);
        rd(8'ha0);
        rd(8'h20);
        give_verdict();
    end
endmodule : supply_ctrl_status_regs_test
`default_nettype wire

// file: hdl/spcsr_octimer.sv
// Purpose: Overcurrent duration timer
// Assumes: Overcurrent input already synchronised
// Notes:   Holds expired high once the overcurrent outlasts the limit, until disarmed or overcurrent ends
`timescale 1ns/1ns
`default_nettype none
module spcsr_octimer #(
    parameter int LIMIT = 50
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic arm,
    input  wire logic overcurrent,
    output var  logic expired
);
    logic [15:0] count;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count   <= 16'h0000;
            expired <= 1'b0;
        end else if (!arm || !overcurrent) begin
            count   <= 16'h0000;
            expired <= 1'b0;
        end else if (count == 16'(LIMIT)) begin
            expired <= 1'b1;
        end else begin
            count   <= count + 16'h0001;
        end
    end
endmodule : spcsr_octimer
`default_nettype wire

// file: hdl/spcsr_pkg.sv
// Purpose: Constants for the supply regulator control and status logic
// Assumes: 50 MHz system clock
// Notes:   Status byte layout, control byte layout, bus address
package spcsr_pkg;
    // ****************************************************************
    // Control byte fields
    // ****************************************************************
    localparam int CTL_LEVEL_LSB   = 0;
    localparam int CTL_RANGE_BIT   = 3;
    localparam int CTL_OCT_BIT     = 4;
    localparam int CTL_EN_BIT      = 5;
    localparam int CTL_CURRENT_LIMIT_SEL_BIT    = 6;
    localparam int CTL_TONE_BIT    = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // ****************************************************************
    // Status byte fields
    // ****************************************************************
    localparam int ST_OT_BIT       = 0;
    localparam int ST_OC_BIT       = 1;
    localparam int ST_PNG_BIT      = 4;
    localparam int ST_DIS_BIT      = 5;
    localparam int ST_UV_BIT       = 7;
    // ****************************************************************
    // Bus address and bit counts
    // ****************************************************************
    localparam logic [4:0] ADDR_FIXED = 5'h02;
    localparam logic [3:0] BITS_BYTE  = 4'h8;
    localparam int OC_TIME_US      = 1;
    localparam int CLK_MHZ         = 50;
    localparam int OC_CYCLES       = OC_TIME_US * CLK_MHZ;
endpackage : spcsr_pkg

// file: hdl/spcsr_sync.sv
// Purpose: Two-flip-flop synchroniser for a level
// Assumes: Input is asynchronous to clk_sys
// Notes:   First stage read only by second stage
`timescale 1ns/1ns
`default_nettype none
module spcsr_sync (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic din,
    output var  logic dout
);
    logic meta;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : spcsr_sync
`default_nettype wire

// file: hdl/spcsr_top.sv
// Functional notes
// - Bus requests ignored until internal logic supply is valid.
// - Logic supply valid raises interrupt and sets undervoltage flag.
// - Interrupt released when own read address acknowledged.
// - One 8-bit control register, all zero at power-up.
// - Bits 0..2 step output level by 333 mV.
// - Bit 3 selects low or high base range.
// - Bit 4 arms overcurrent disable timer.
// - Bit 5 enables supply output.
// - Bit 6 selects 500 mA or 700 mA current limit.
// - Bit 7 gates 22 kHz tone modulation.
// - Fault flags stay set until a status read.
// - Only disabled and not-good flags clear without a read.
// - Overtemperature sets bit 0, disabled flag, output off.
// - Ninth read clock resamples overtemperature flag.
// - Timed overcurrent with timer armed sets bit 1, output off.
// - Ninth read clock resamples timed overcurrent flag.
// - Timer off: stay in limit, never set overcurrent flag.
// - Bit 4 set below 85 percent, cleared within 90 percent.
// - Bit 5 set at power-on and faults, no interrupt.
// - Write end clears disabled flag if output enabled.
// - Input undervoltage sets bit 7, disabled flag, output off.
// - Ninth read clock resamples undervoltage flag.
// - Four-bit code maps to sixteen output levels.
// - Slave address is 00010 plus two select bits.
// - Only power-up, overtemp, undervoltage, overcurrent raise interrupt.
//
// Purpose: Two-wire slave with control and fault status registers
// Assumes: Serial pins oversampled by clk_sys; analog inputs asynchronous
// Notes:   Analog regulation lives outside; this drives its controls
`timescale 1ns/1ns
`default_nettype none
module spcsr_top
    import spcsr_pkg::*;
#(
    parameter int OC_LIMIT = spcsr_pkg::OC_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       logic_supply_ok,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            irq_out,
    output logic            irq_oe,
    input  wire logic [1:0] addr_sel,
    input  wire logic       overtemp_in,
    input  wire logic       overcurrent_in,
    input  wire logic       input_uv_in,
    input  wire logic       below_85_in,
    input  wire logic       within_90_in,
    output logic [3:0]      level_code,
    output logic            overcurrent_timer_en,
    output logic            output_active,
    output logic            current_limit_sel,
    output logic            tone_enable
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [7:0] raw_in;
    logic [7:0] syn;
    assign raw_in = {logic_supply_ok, scl_in, sda_in, overtemp_in,
                     overcurrent_in, input_uv_in, below_85_in,
                     within_90_in};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            spcsr_sync u_sync (
                .clk_sys (clk_sys),
                .nrst    (nrst),
                .din     (raw_in[gi]),
                .dout    (syn[gi])
            );
        end
    endgenerate
    logic supply_ok, scl, sda, ot, oc, uv, lo85, in90;
    assign {supply_ok, scl, sda, ot, oc, uv, lo85, in90} = syn;

    logic scl_d, sda_d;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    assign start_c  = scl & scl_d & sda_d & ~sda;
    assign stop_c   = scl & scl_d & ~sda_d & sda;
    // ****************************************************************
    // Serial slave state machine
    // ****************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_WDATA, S_WACK, S_RDATA, S_RACK
    } spcsr_state_e;
    spcsr_state_e state;
    logic [3:0]   bitcnt;
    logic [7:0]   shreg;
    logic         is_read;
    logic         drive_low;
    logic         write_done;
    logic         addr_acked;
    logic         read_ninth;
    logic         data_latched;
    logic [7:0]   status;
    logic [7:0]   control;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state        <= S_IDLE;
            bitcnt       <= 4'h0;
            shreg        <= 8'h00;
            is_read      <= 1'b0;
            drive_low    <= 1'b0;
            write_done   <= 1'b0;
            addr_acked   <= 1'b0;
            read_ninth   <= 1'b0;
            data_latched <= 1'b0;
        end else begin
            write_done <= 1'b0;
            addr_acked <= 1'b0;
            read_ninth <= 1'b0;
            if (!supply_ok) begin
                state     <= S_IDLE;
                drive_low <= 1'b0;
            end else if (start_c) begin
                state     <= S_ADDR;
                bitcnt    <= 4'h0;
                drive_low <= 1'b0;
            end else if (stop_c) begin
                state        <= S_IDLE;
                drive_low    <= 1'b0;
                write_done   <= data_latched;
                data_latched <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: drive_low <= 1'b0;
                    S_ADDR: begin
                        if (scl_rise) begin
                            shreg  <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == BITS_BYTE) begin
                            if (shreg[7:1] == {ADDR_FIXED, addr_sel}) begin
                                state     <= S_ADDR_ACK;
                                is_read   <= shreg[0];
                                drive_low <= 1'b1;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        if (scl_rise) begin
                            addr_acked <= is_read;
                        end
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (is_read) begin
                                state     <= S_RDATA;
                                shreg     <= status;
                                drive_low <= ~status[7];
                            end else begin
                                state     <= S_WDATA;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    S_WDATA: begin
                        if (scl_rise) begin
                            shreg  <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == BITS_BYTE) begin
                            state        <= S_WACK;
                            drive_low    <= 1'b1;
                            data_latched <= 1'b1;
                        end
                    end
                    S_WACK: begin
                        if (scl_fall) begin
                            state     <= S_IDLE;
                            drive_low <= 1'b0;
                        end
                    end
                    S_RDATA: begin
                        if (scl_fall) begin
                            if (bitcnt == BITS_BYTE - 4'h1) begin
                                state     <= S_RACK;
                                drive_low <= 1'b0;
                            end else begin
                                shreg     <= {shreg[6:0], 1'b0};
                                drive_low <= ~shreg[6];
                                bitcnt    <= bitcnt + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            read_ninth <= 1'b1;
                            is_read    <= ~sda;
                        end
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (is_read) begin
                                state     <= S_RDATA;
                                shreg     <= status;
                                drive_low <= ~status[7];
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            control <= CTL_RESET;
        end else if (state == S_WACK && scl_fall) begin
            control <= shreg;
        end
    end
    // ****************************************************************
    // Fault detection
    // ****************************************************************
    logic oc_expired;
    spcsr_octimer #(
        .LIMIT (OC_LIMIT)
    ) u_octimer (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .arm         (control[CTL_OCT_BIT]),
        .overcurrent (oc),
        .expired     (oc_expired)
    );
    // ****************************************************************
    // Status flags
    // ****************************************************************
    logic supply_seen;
    logic f_ot, f_oc, f_uv, f_png, f_dis;
    logic new_fault;
    assign new_fault = (ot & ~f_ot) | (oc_expired & ~f_oc) | (uv & ~f_uv);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            supply_seen <= 1'b0;
            f_ot        <= 1'b0;
            f_oc        <= 1'b0;
            f_uv        <= 1'b0;
            f_dis       <= 1'b1;
        end else if (supply_ok) begin
            supply_seen <= 1'b1;
            // Set wins over the read resample
            f_ot <= ot | (f_ot & ~read_ninth);
            f_oc <= oc_expired | (f_oc & ~read_ninth);
            f_uv <= uv | ~supply_seen
                  | (f_uv & ~read_ninth);
            if (ot | oc_expired | uv | ~supply_seen) begin
                f_dis <= 1'b1;
            end else if (write_done && control[CTL_EN_BIT]) begin
                f_dis <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            f_png <= 1'b0;
        end else if (output_active && lo85) begin
            f_png <= 1'b1;
        end else if (!output_active || in90) begin
            f_png <= 1'b0;
        end
    end
    always_comb begin
        status              = 8'h00;
        status[ST_OT_BIT]   = f_ot;
        status[ST_OC_BIT]   = f_oc;
        status[ST_PNG_BIT]  = f_png;
        status[ST_DIS_BIT]  = f_dis;
        status[ST_UV_BIT]   = f_uv;
    end
    // ****************************************************************
    // Interrupt request
    // ****************************************************************
    logic irq_pend;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_pend <= 1'b0;
        end else if (!supply_ok) begin
            irq_pend <= 1'b0;
        end else if (~supply_seen | new_fault) begin
            irq_pend <= 1'b1;
        end else if (addr_acked) begin
            irq_pend <= 1'b0;
        end
    end
    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sda_out              <= 1'b0;
            sda_oe               <= 1'b0;
            irq_out              <= 1'b0;
            irq_oe               <= 1'b0;
            level_code           <= 4'h0;
            overcurrent_timer_en <= 1'b0;
            output_active        <= 1'b0;
            current_limit_sel    <= 1'b0;
            tone_enable          <= 1'b0;
        end else begin
            sda_oe               <= drive_low;
            irq_oe               <= irq_pend;
            level_code           <= control[CTL_RANGE_BIT:CTL_LEVEL_LSB];
            overcurrent_timer_en <= control[CTL_OCT_BIT];
            output_active        <= control[CTL_EN_BIT] & ~f_dis;
            current_limit_sel    <= control[CTL_CURRENT_LIMIT_SEL_BIT];
            tone_enable          <= control[CTL_TONE_BIT];
        end
    end
endmodule : spcsr_top
`default_nettype wire
